//--- core/elic_hdb3_enc.sv
// transmit line encoder: hdb3 substitution or plain ami, dual or single rail
`timescale 1ns/10ps
`default_nettype none
module elic_hdb3_enc (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bit_en,
  input wire logic data_bit,
  input wire logic hdb3_en,
  input wire logic single_rail,
  output elic_pkg::elic_rail_type rail
);
  import elic_pkg::*;

  elic_enc_type q;
  elic_enc_type d;
  logic subst;
  logic p;

  always_comb begin
    d = q;
    p = q.pol;
    // single rail hands raw data to the line unit, which does its own coding
    subst = hdb3_en && !single_rail && !data_bit && (q.tok[2:0] == {3{TOK_ZERO}});
    if (bit_en) begin
      d.tok[3:1] = q.tok[2:0];
      d.tok[0] = data_bit ? TOK_MARK : TOK_ZERO;
      if (subst) begin
        d.tok[0] = TOK_VIOL;
        if (!q.odd) begin
          d.tok[3] = TOK_MARK;
        end
        d.odd = 1'b0;
      end else if (data_bit) begin
        d.odd = ~q.odd;
      end
      d.rail = '0;
      if (single_rail) begin
        d.rail.pos = (q.tok[3] != TOK_ZERO);
      end else if (q.tok[3] == TOK_MARK) begin
        p = ~q.pol;
        d.pol = p;
        d.rail = p ? 2'b10 : 2'b01;
      end else if (q.tok[3] == TOK_VIOL) begin
        d.rail = q.pol ? 2'b10 : 2'b01;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rail = q.rail;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ami_no_violation_a: assert property (bit_en && !hdb3_en |=> q.tok[0] != TOK_VIOL)
    else $error("violation inserted while encoder disabled");
  hdb3_four_zeros_a: assert property (bit_en && subst |=> q.tok[0] == TOK_VIOL)
    else $error("four zeros not substituted");

endmodule : elic_hdb3_enc
`default_nettype wire

//--- core/elic_line_ctrl.sv
// e1 line interface control: control register, loopbacks, rail select, line coding
//
// Behaviour
// - force_signal_loss_pattern bit sends no-pulse pattern to line
// - bit six picks single or dual rail
// - bits five-four pick loopback, zero is none
// - local loop returns transmit pcm to receive
// - local loop ignores line, sends all ones
// - remote loop returns decoded line data, no framing
// - payload loop reframes receive slots on transmit timing
// - bit one disables hdb3 encoder, ami sent
// - bit zero disables hdb3 decoder, ami received
`timescale 1ns/10ps
`default_nettype none
module elic_line_ctrl #(
  parameter int unsigned BIT_DIV = elic_pkg::BIT_DIV_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_pcm_bit,
  input wire elic_pkg::elic_rail_type receive_line_pair,
  output logic rx_pcm_bit,
  output elic_pkg::elic_rail_type tx_line_pair,
  output logic bit_strobe
);
  import elic_pkg::*;

  elic_state_type q;
  elic_state_type d;
  elic_rail_type enc_rail;
  logic addr_phase;
  logic mark;
  logic viol;
  logic rx_dec;
  logic tx_src;

  function automatic logic [7:0] read_reg(input logic [31:0] a, input elic_ctl_type c,
                                          input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (a == CTRL_OFFSET) begin
      r = c;
    end else if (a == STAT_OFFSET) begin
      r = v;
    end
    return r;
  endfunction : read_reg

  assign addr_phase = hsel && htrans[1] && hready;
  assign rx_dec = q.dwin[3];

  always_comb begin
    d = q;
    // bit-rate enable
    d.strobe = (q.div == 8'(BIT_DIV - 1));
    d.div = d.strobe ? 8'h00 : 8'(q.div + 8'h01);
    // line pins: three stages, change accepted when stages two and three agree
    d.s1 = receive_line_pair;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.filt = q.s3;
    end
    // bus slave, zero wait states; write lands before a following read samples it
    if (q.wr_pend && q.wr_addr == CTRL_OFFSET) begin
      d.ctl = elic_ctl_type'(hwdata[7:0]);
    end
    if (hready) begin
      d.wr_pend = addr_phase && hwrite;
      d.wr_addr = haddr;
    end
    if (addr_phase && !hwrite) begin
      d.rdata = read_reg(haddr, d.ctl, q.viol_cnt);
    end
    // receive decoder
    if (q.ctl.single_rail_select) begin
      mark = q.filt.pos;
      viol = 1'b0;
    end else begin
      mark = q.filt.pos || q.filt.neg;
      viol = mark && !q.ctl.line_decoder_disable && (q.filt.pos == q.rx_pol);
    end
    // transmit source per loopback mode
    unique case (q.ctl.framer_loop_select)
      LOOP_NONE: tx_src = tx_pcm_bit;
      LOOP_LOCAL: tx_src = 1'b1;
      LOOP_REMOTE: tx_src = rx_dec;
      LOOP_PAYLOAD: tx_src = (q.slot_cnt < SLOT_BITS) ? tx_pcm_bit : rx_dec;
    endcase
    if (q.strobe) begin
      d.slot_cnt = 8'(q.slot_cnt + 8'h01);
      if (mark && !q.ctl.single_rail_select) begin
        d.rx_pol = q.filt.pos;
      end
      d.dwin = {q.dwin[2:0], mark};
      if (viol) begin
        d.dwin = 4'h0;
        d.viol_cnt = 8'(q.viol_cnt + 8'h01);
      end
      d.rx_pcm = (q.ctl.framer_loop_select == LOOP_LOCAL) ? tx_pcm_bit : rx_dec;
    end
    d.line = q.ctl.force_signal_loss_pattern ? 2'b00 : enc_rail;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  elic_hdb3_enc u_enc (
    .clock(clock),
    .rstn(rstn),
    .bit_en(q.strobe),
    .data_bit(tx_src),
    .hdb3_en(!q.ctl.line_encoder_disable),
    .single_rail(q.ctl.single_rail_select),
    .rail(enc_rail)
  );

  assign hrdata = {24'h000000, q.rdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rx_pcm_bit = q.rx_pcm;
  assign tx_line_pair = q.line;
  assign bit_strobe = q.strobe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  force_signal_loss_pattern_out_a: assert property (q.ctl.force_signal_loss_pattern |=> tx_line_pair == 2'b00)
    else $error("pulses on line while loss pattern forced");
  // encoder rail moves only on a strobe, then passes the line register
  single_rail_neg_a: assert property (q.strobe && q.ctl.single_rail_select
                                      |-> ##2 !tx_line_pair.neg)
    else $error("negative rail active in single rail mode");
  no_loop_rx_a: assert property (q.strobe && q.ctl.framer_loop_select == LOOP_NONE
                                 |=> rx_pcm_bit == $past(q.dwin[3]))
    else $error("receive output not from line in normal mode");
  local_loop_rx_a: assert property (q.strobe && q.ctl.framer_loop_select == LOOP_LOCAL
                                    |=> rx_pcm_bit == $past(tx_pcm_bit))
    else $error("local loop does not return transmit data");
  local_all_ones_a: assert property (q.ctl.framer_loop_select == LOOP_LOCAL |-> tx_src)
    else $error("local loop not sending all ones");
  remote_loop_src_a: assert property (q.ctl.framer_loop_select == LOOP_REMOTE
                                      |-> tx_src == q.dwin[3])
    else $error("remote loop not returning decoded line data");
  payload_slots_a: assert property (q.ctl.framer_loop_select == LOOP_PAYLOAD
                                    && q.slot_cnt >= SLOT_BITS |-> tx_src == q.dwin[3])
    else $error("payload slot not taken from receive data");
  decoder_off_a: assert property (q.ctl.line_decoder_disable
                                  |=> q.viol_cnt == $past(q.viol_cnt))
    else $error("violation decoded while decoder disabled");
  reset_ctl_a: assert property (@(posedge clock) disable iff (1'b0)
                                $rose(rstn) |-> q.ctl == CTRL_RESET)
    else $error("control register not zero after reset");
  write_next_a: assert property (q.wr_pend && q.wr_addr == CTRL_OFFSET
                                 |=> q.ctl == $past(hwdata[7:0]))
    else $error("control write not taken");

endmodule : elic_line_ctrl
`default_nettype wire

//--- pkg/elic_pkg.sv
// package: register map, field layout, timing and state types of the e1 line control block
package elic_pkg;

  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STAT_OFFSET = 32'h0000_0004;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned FORCE_SIGNAL_LOSS_PATTERN_BIT = 7;
  localparam int unsigned SINGLE_RAIL_BIT = 6;
  localparam int unsigned LOOP_LSB = 4;
  localparam int unsigned ENC_DIS_BIT = 1;
  localparam int unsigned DEC_DIS_BIT = 0;
  localparam int unsigned BIT_DIV_DEFAULT = 10;
  localparam logic [7:0] SLOT_BITS = 8'h08;

  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_LOCAL,
    LOOP_REMOTE,
    LOOP_PAYLOAD
  } elic_loop_type;

  typedef enum logic [1:0] {
    TOK_ZERO,
    TOK_MARK,
    TOK_VIOL
  } elic_tok_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } elic_rail_type;

  // field order matches the control register bit layout 7..0
  typedef struct packed {
    logic force_signal_loss_pattern;
    logic single_rail_select;
    elic_loop_type framer_loop_select;
    logic [1:0] reserved;
    logic line_encoder_disable;
    logic line_decoder_disable;
  } elic_ctl_type;

  typedef struct packed {
    elic_tok_type [3:0] tok;
    logic odd;
    logic pol;
    elic_rail_type rail;
  } elic_enc_type;

  typedef struct packed {
    elic_ctl_type ctl;
    logic [7:0] viol_cnt;
    logic [7:0] rdata;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [7:0] div;
    logic strobe;
    logic [7:0] slot_cnt;
    elic_rail_type s1;
    elic_rail_type s2;
    elic_rail_type s3;
    elic_rail_type filt;
    logic [3:0] dwin;
    logic rx_pol;
    logic rx_pcm;
    elic_rail_type line;
  } elic_state_type;

endpackage : elic_pkg

//--- verification/elic_liu_model.sv
// line interface unit model: dual rail ami or single rail data source driving the receive line pins
`timescale 1ns/10ps
`default_nettype none
module elic_liu_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bit_strobe,
  input wire logic single_rail,
  input wire logic send_bit,
  output var elic_pkg::elic_rail_type line
);
  import elic_pkg::*;
  logic pol_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line <= 2'b00;
      pol_q <= 1'b0;
    end else if (bit_strobe) begin
      if (single_rail) begin
        line <= {send_bit, 1'b0};
      end else begin
        // dual rail marks alternate polarity, zeros carry no pulse
        line <= send_bit ? (pol_q ? 2'b01 : 2'b10) : 2'b00;
        pol_q <= pol_q ^ send_bit;
      end
    end
  end
endmodule : elic_liu_model
`default_nettype wire

//--- verification/testbench.sv
// testbench for the e1 line interface control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import elic_pkg::*;
  localparam int BDIV = 4;
  logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic tx_pcm_bit, rx_pcm_bit, bit_strobe, single_rail, send_bit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  elic_rail_type rx_pair, tx_pair;
  int fail_count, checked, cyc, pos_n, neg_n, both_n, rx1_n;
  assign hready = hreadyout;
  elic_line_ctrl #(.BIT_DIV(BDIV)) u_dut (.clock(clock), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_pcm_bit(tx_pcm_bit), .receive_line_pair(rx_pair), .rx_pcm_bit(rx_pcm_bit),
    .tx_line_pair(tx_pair), .bit_strobe(bit_strobe));
  elic_liu_model u_liu (.clock(clock), .rstn(rstn), .bit_strobe(bit_strobe),
    .single_rail(single_rail), .send_bit(send_bit), .line(rx_pair));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // counts line pulses and receive ones over n bit periods
  task automatic watch(input int n);
    pos_n = 0;
    neg_n = 0;
    both_n = 0;
    rx1_n = 0;
    repeat (n * BDIV) begin
      @(posedge clock);
      #1;
      pos_n += int'(tx_pair.pos);
      neg_n += int'(tx_pair.neg);
      both_n += int'(tx_pair.pos & tx_pair.neg);
      rx1_n += int'(rx_pcm_bit);
    end
  endtask : watch
  task automatic mode(input logic [7:0] c, input logic t, input logic s);
    ahb(CTRL_OFFSET, 1'b1, {24'h000000, c});
    tx_pcm_bit <= t;
    send_bit <= s;
    watch(40);
    watch(32);
  endtask : mode
  task automatic test_regs();
    ahb(CTRL_OFFSET, 1'b0, 32'h0);
    check_word(rd, {24'h000000, CTRL_RESET});
    check_flag(hresp, 1'b0);
    ahb(STAT_OFFSET, 1'b0, 32'h0);
    check_word(rd, 32'h0000_0000);
    ahb(CTRL_OFFSET, 1'b1, 32'h0000_0033);
    ahb(CTRL_OFFSET, 1'b0, 32'h0);
    check_word(rd, 32'h0000_0033);
    ahb(32'h0000_0008, 1'b0, 32'h0);
    check_word(rd, 32'h0000_0000);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_normal();
    mode(8'h00, 1'b1, 1'b0);
    check_flag(pos_n > 0 && neg_n > 0 && both_n == 0, 1'b1);
    check_flag(rx1_n == 0, 1'b1);
    mode(8'h02, 1'b0, 1'b1);
    check_flag(pos_n + neg_n == 0, 1'b1);
    check_flag(rx1_n == 32 * BDIV, 1'b1);
    mode(8'h00, 1'b0, 1'b1);
    // zero runs get substitution pulses only with the encoder on
    check_flag(pos_n > 0, 1'b1);
    mode(8'h01, 1'b0, 1'b1);
    check_flag(rx1_n == 32 * BDIV, 1'b1);
    $display("test_normal done");
  endtask : test_normal
  task automatic test_force();
    mode(8'h80, 1'b1, 1'b1);
    check_flag(pos_n + neg_n == 0, 1'b1);
    $display("test_force done");
  endtask : test_force
  task automatic test_local();
    mode(8'h10, 1'b1, 1'b0);
    check_flag(rx1_n == 32 * BDIV, 1'b1);
    check_flag(pos_n > 0 && neg_n > 0 && both_n == 0, 1'b1);
    mode(8'h10, 1'b0, 1'b1);
    check_flag(rx1_n == 0, 1'b1);
    $display("test_local done");
  endtask : test_local
  task automatic test_loops();
    mode(8'h22, 1'b0, 1'b1);
    check_flag(pos_n > 0 && neg_n > 0, 1'b1);
    mode(8'h32, 1'b0, 1'b1);
    check_flag(pos_n > 0, 1'b1);
    $display("test_loops done");
  endtask : test_loops
  task automatic test_single();
    single_rail <= 1'b1;
    mode(8'h42, 1'b1, 1'b1);
    check_flag(pos_n > 0 && neg_n == 0, 1'b1);
    check_flag(rx1_n == 32 * BDIV, 1'b1);
    single_rail <= 1'b0;
    $display("test_single done");
  endtask : test_single
  initial begin
    {hsel, hwrite, tx_pcm_bit, single_rail, send_bit, rstn} = 6'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    test_regs();
    test_normal();
    test_force();
    test_local();
    test_loops();
    test_single();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
